/* core/can_main_control_modes.sv */
// Purpose: Main control register and mode sequencing of a CAN controller.
// Assumes: APB slave, zero wait states; bit_tick and debug_halt come from pclk logic.
// Notes:   can_rx is a pin and is synchronised before use.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module can_main_control_modes (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link and core status
  input  wire logic        can_rx,
  input  wire logic        bit_tick,
  input  wire logic [8:0]  tx_error_counter,
  input  wire logic        debug_halt,
  // Mode outputs
  output logic             init_mode,
  output logic             sleep_mode,
  output logic             busoff_flag,
  output logic             bus_enable,
  output logic             tx_priority_select,
  output logic             rx_lock_select,
  output logic             retransmit_disable
);

  can_main_control_pkg::mode_e mode_reg;
  can_main_control_pkg::mode_e mode_next;

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic        rx_prev_reg;
  logic        busoff_reg;
  logic        busoff_next;
  logic        init_set_seen_reg;
  logic        init_set_seen_next;
  logic        init_cycle_done_reg;
  logic        init_cycle_done_next;
  logic        frozen_next;
  logic        enable_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        init_mode_reg;
  logic        sleep_mode_reg;
  logic        busoff_flag_reg;
  logic        bus_enable_reg;
  logic        tx_pri_reg;
  logic        rx_lock_reg;
  logic        retx_reg;
  logic        boot_reg;
  logic        rx_activity;
  logic        recovery_done;
  logic        recovery_enable;
  logic        setup_phase;
  logic        ctrl_write;
  logic        addr_ctrl;
  logic        addr_status;

  // Receive pin synchroniser; the second stage and the third stage (rx_prev_reg, its delayed copy) are looked at.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= can_rx;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // A start-of-frame edge to dominant is taken as message activity.
  assign rx_activity = rx_prev_reg & ~rx_sync_reg;

  assign addr_ctrl   = (paddr == can_main_control_pkg::MAIN_CONTROL_OFFSET);
  assign addr_status = (paddr == can_main_control_pkg::MODE_STATUS_OFFSET);
  assign setup_phase = psel & ~penable;
  assign ctrl_write  = psel & penable & pready_reg & pwrite & addr_ctrl;

  // Control register: hardware wakeup clear first, a software write in the same cycle wins.
  always_comb begin
    ctrl_next = ctrl_reg;
    // RULE3 hardware sleep clear
    if (mode_reg == can_main_control_pkg::MODE_SLEEP && ctrl_reg[can_main_control_pkg::WAKEUP_BIT]
        && rx_activity) begin
      ctrl_next[can_main_control_pkg::SLEEP_BIT] = 1'b0;
    end
    if (ctrl_write) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          ctrl_next[8*i +: 8] = pwdata[8*i +: 8] & can_main_control_pkg::MAIN_CONTROL_MASK[8*i +: 8];
        end
      end
    end
  end

  // Mode sequencing; an init request outranks a sleep request in normal mode, but sleep mode is left only once the sleep request clears.
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      can_main_control_pkg::MODE_SLEEP: begin
        // RULE2 leave sleep
        // RULE8 wake on cleared request
        if (!ctrl_reg[can_main_control_pkg::SLEEP_BIT]) begin
          mode_next = ctrl_reg[can_main_control_pkg::INIT_BIT] ? can_main_control_pkg::MODE_INIT
                                                               : can_main_control_pkg::MODE_NORMAL;
        end
      end
      can_main_control_pkg::MODE_INIT: begin
        // RULE1 init exit
        if (!ctrl_reg[can_main_control_pkg::INIT_BIT]) begin
          mode_next = ctrl_reg[can_main_control_pkg::SLEEP_BIT] ? can_main_control_pkg::MODE_SLEEP
                                                                : can_main_control_pkg::MODE_NORMAL;
        end
      end
      can_main_control_pkg::MODE_NORMAL: begin
        // RULE1 init entry
        if (ctrl_reg[can_main_control_pkg::INIT_BIT]) begin
          mode_next = can_main_control_pkg::MODE_INIT;
        // RULE2 sleep entry
        end else if (ctrl_reg[can_main_control_pkg::SLEEP_BIT]) begin
          mode_next = can_main_control_pkg::MODE_SLEEP;
        end
      end
      default: begin
        mode_next = can_main_control_pkg::MODE_SLEEP;
      end
    endcase
  end

  // RULE10 init set then cleared
  assign recovery_enable = busoff_reg & (ctrl_reg[can_main_control_pkg::BUSOFF_LEAVE_BIT] | init_cycle_done_reg);

  // RULE9 recessive run count
  recessive_run_counter #(
    .RUN_BITS (can_main_control_pkg::RECESSIVE_RUN_BITS),
    .RUNS     (can_main_control_pkg::RECESSIVE_RUNS)
  ) u_recovery (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (recovery_enable),
    .bit_tick (bit_tick),
    .rx_level (rx_sync_reg),
    .done     (recovery_done)
  );

  // Bus-off tracking; entry wins over recovery in the same cycle.
  always_comb begin
    busoff_next          = busoff_reg;
    init_set_seen_next   = init_set_seen_reg;
    init_cycle_done_next = init_cycle_done_reg;
    if (busoff_reg) begin
      if (ctrl_reg[can_main_control_pkg::INIT_BIT]) begin
        init_set_seen_next = 1'b1;
      end else if (init_set_seen_reg) begin
        init_cycle_done_next = 1'b1;
      end
      if (recovery_done) begin
        busoff_next = 1'b0;
      end
    end else begin
      init_set_seen_next   = 1'b0;
      init_cycle_done_next = 1'b0;
    end
    // RULE12 bus-off entry
    if (tx_error_counter > can_main_control_pkg::BUSOFF_LIMIT) begin
      busoff_next = 1'b1;
    end
  end

  // RULE11 debug freeze
  assign frozen_next = ctrl_reg[can_main_control_pkg::FREEZE_BIT] & debug_halt;
  // RULE12 no traffic in bus-off
  assign enable_next = (mode_next == can_main_control_pkg::MODE_NORMAL) & ~busoff_next & ~frozen_next;

  // APB answer is prepared in the setup cycle and shown in the single access cycle.
  always_comb begin
    prdata_next  = '0;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      if (addr_ctrl) begin
        prdata_next = ctrl_reg;
      end else if (addr_status) begin
        prdata_next[can_main_control_pkg::ST_INIT_BIT]   = init_mode_reg;
        prdata_next[can_main_control_pkg::ST_SLEEP_BIT]  = sleep_mode_reg;
        prdata_next[can_main_control_pkg::ST_BUSOFF_BIT] = busoff_flag_reg;
        prdata_next[can_main_control_pkg::ST_FROZEN_BIT] = frozen_next;
        prdata_next[can_main_control_pkg::ST_ENABLE_BIT] = bus_enable_reg;
        prdata_next[can_main_control_pkg::ST_RX_BIT]     = rx_sync_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE4 reset value
      ctrl_reg            <= can_main_control_pkg::MAIN_CONTROL_RESET;
      mode_reg            <= can_main_control_pkg::MODE_SLEEP;
      busoff_reg          <= 1'b0;
      init_set_seen_reg   <= 1'b0;
      init_cycle_done_reg <= 1'b0;
      prdata_reg          <= '0;
      pready_reg          <= 1'b0;
      pslverr_reg         <= 1'b0;
      init_mode_reg       <= 1'b0;
      sleep_mode_reg      <= 1'b1;
      busoff_flag_reg     <= 1'b0;
      bus_enable_reg      <= 1'b0;
      tx_pri_reg          <= 1'b0;
      rx_lock_reg         <= 1'b0;
      retx_reg            <= 1'b0;
      boot_reg            <= 1'b1;
    end else begin
      ctrl_reg            <= ctrl_next;
      mode_reg            <= mode_next;
      busoff_reg          <= busoff_next;
      init_set_seen_reg   <= init_set_seen_next;
      init_cycle_done_reg <= init_cycle_done_next;
      prdata_reg          <= prdata_next;
      pready_reg          <= setup_phase;
      pslverr_reg         <= pslverr_next;
      init_mode_reg       <= (mode_next == can_main_control_pkg::MODE_INIT);
      sleep_mode_reg      <= (mode_next == can_main_control_pkg::MODE_SLEEP);
      busoff_flag_reg     <= busoff_next;
      bus_enable_reg      <= enable_next;
      // RULE5 priority order select
      tx_pri_reg          <= ctrl_reg[can_main_control_pkg::TX_PRIORITY_BIT];
      // RULE6 overrun lock select
      rx_lock_reg         <= ctrl_reg[can_main_control_pkg::RX_LOCK_BIT];
      // RULE7 single shot select
      retx_reg            <= ctrl_reg[can_main_control_pkg::RETRANSMIT_BIT];
      boot_reg            <= 1'b0;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign init_mode          = init_mode_reg;
  assign sleep_mode         = sleep_mode_reg;
  assign busoff_flag        = busoff_flag_reg;
  assign bus_enable         = bus_enable_reg;
  assign tx_priority_select = tx_pri_reg;
  assign rx_lock_select     = rx_lock_reg;
  assign retransmit_disable = retx_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sleep_cleared;
    !ctrl_reg[can_main_control_pkg::SLEEP_BIT];
  endsequence

  sequence s_awake;
    !sleep_mode ##0 (init_mode || mode_reg == can_main_control_pkg::MODE_NORMAL);
  endsequence

  property p_reset_value;
    boot_reg |-> ctrl_reg == can_main_control_pkg::MAIN_CONTROL_RESET && sleep_mode && !bus_enable;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("control register reset value wrong"); // RULE4

  property p_init_entry;
    mode_reg == can_main_control_pkg::MODE_NORMAL && ctrl_reg[can_main_control_pkg::INIT_BIT]
      |=> init_mode && !bus_enable;
  endproperty
  a_init_entry: assert property (p_init_entry) else $error("init request did not enter init mode"); // RULE1

  property p_init_exit;
    init_mode && !ctrl_reg[can_main_control_pkg::INIT_BIT] && !ctrl_reg[can_main_control_pkg::SLEEP_BIT]
      |=> !init_mode && mode_reg == can_main_control_pkg::MODE_NORMAL;
  endproperty
  a_init_exit: assert property (p_init_exit) else $error("init clear did not return to normal"); // RULE1

  property p_sleep_entry;
    mode_reg == can_main_control_pkg::MODE_NORMAL && ctrl_reg[can_main_control_pkg::SLEEP_BIT]
      && !ctrl_reg[can_main_control_pkg::INIT_BIT] |=> sleep_mode;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request did not enter sleep"); // RULE2

  property p_auto_wake;
    sleep_mode && mode_reg == can_main_control_pkg::MODE_SLEEP && ctrl_reg[can_main_control_pkg::WAKEUP_BIT]
      && rx_activity && !ctrl_write |=> s_sleep_cleared ##1 s_awake;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("bus activity did not wake the controller"); // RULE3

  property p_manual_wake;
    mode_reg == can_main_control_pkg::MODE_SLEEP && !ctrl_reg[can_main_control_pkg::WAKEUP_BIT]
      && ctrl_reg[can_main_control_pkg::SLEEP_BIT] && !ctrl_write |=> ctrl_reg[can_main_control_pkg::SLEEP_BIT]
      ##1 sleep_mode;
  endproperty
  a_manual_wake: assert property (p_manual_wake) else $error("sleep ended without software"); // RULE8

  property p_selects;
    ##1 tx_priority_select == $past(ctrl_reg[can_main_control_pkg::TX_PRIORITY_BIT])
      && rx_lock_select == $past(ctrl_reg[can_main_control_pkg::RX_LOCK_BIT]);
  endproperty
  a_selects: assert property (p_selects) else $error("priority or lock select out of step"); // RULE5

  property p_retransmit;
    $rose(ctrl_reg[can_main_control_pkg::RETRANSMIT_BIT]) |=> retransmit_disable;
  endproperty
  a_retransmit: assert property (p_retransmit) else $error("retransmit disable not passed on"); // RULE7

  property p_busoff_entry;
    tx_error_counter > can_main_control_pkg::BUSOFF_LIMIT |=> busoff_flag && !bus_enable;
  endproperty
  a_busoff_entry: assert property (p_busoff_entry) else $error("error count above limit without bus-off"); // RULE12

  property p_busoff_auto;
    busoff_reg && recovery_done && ctrl_reg[can_main_control_pkg::BUSOFF_LEAVE_BIT]
      && tx_error_counter <= can_main_control_pkg::BUSOFF_LIMIT |=> !busoff_flag;
  endproperty
  a_busoff_auto: assert property (p_busoff_auto) else $error("bus-off not left after recessive runs"); // RULE9

  property p_busoff_hold;
    busoff_reg && !ctrl_reg[can_main_control_pkg::BUSOFF_LEAVE_BIT] && !init_cycle_done_reg
      |=> busoff_flag [*2];
  endproperty
  a_busoff_hold: assert property (p_busoff_hold) else $error("bus-off left before init set and clear"); // RULE10

  property p_freeze;
    ctrl_reg[can_main_control_pkg::FREEZE_BIT] && debug_halt |=> !bus_enable;
  endproperty
  a_freeze: assert property (p_freeze) else $error("traffic allowed while frozen"); // RULE11

endmodule

/* core/can_main_control_pkg.sv */
// Purpose: Shared constants and types of the CAN main control block.
// Assumes: One APB register word per offset, 32-bit data.
// Notes:   Offsets are byte addresses on the APB side.
//
// Notes on behaviour
// RULE1 - Control bit 0 set moves the controller into initialization mode and cleared returns it to normal operation.
// RULE2 - Control bit 1 written 1 asks for sleep mode and written 0 leaves sleep mode.
// RULE3 - With automatic wakeup chosen, hardware clears the sleep request bit when it sees activity on the receive line.
// RULE4 - After reset the control register reads 0x00010002, so the controller starts asleep.
// RULE5 - The transmit priority select bit picks identifier order at 0 and request order at 1.
// RULE6 - The lock select bit lets a new message overwrite a full unread FIFO at 0 and discards it at 1.
// RULE7 - The retransmit disable bit at 0 retries until success and at 1 sends each message once.
// RULE8 - With wakeup select at 0 only software ends sleep, at 1 a detected message ends it too.
// RULE9 - With automatic bus-off leaving set, bus-off ends after 128 runs of 11 recessive bits.
// RULE10 - With automatic bus-off leaving clear, software must set then clear the init request before the run count applies.
// RULE11 - With debug freeze set and the processor halted, the controller stops receiving and transmitting.
// RULE12 - A transmit error count above 255 puts the controller in bus-off, where it neither sends nor receives.
package can_main_control_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte offsets.
  localparam logic [11:0] MAIN_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] MODE_STATUS_OFFSET  = 12'h004;

  // Control field positions.
  localparam int unsigned INIT_BIT         = 0;
  localparam int unsigned SLEEP_BIT        = 1;
  localparam int unsigned TX_PRIORITY_BIT  = 2;
  localparam int unsigned RX_LOCK_BIT      = 3;
  localparam int unsigned RETRANSMIT_BIT   = 4;
  localparam int unsigned WAKEUP_BIT       = 5;
  localparam int unsigned BUSOFF_LEAVE_BIT = 6;
  localparam int unsigned FREEZE_BIT       = 16;

  localparam logic [31:0] MAIN_CONTROL_RESET = 32'h0001_0002;
  localparam logic [31:0] MAIN_CONTROL_MASK  = 32'h0001_007F;

  // Status field positions.
  localparam int unsigned ST_INIT_BIT   = 0;
  localparam int unsigned ST_SLEEP_BIT  = 1;
  localparam int unsigned ST_BUSOFF_BIT = 2;
  localparam int unsigned ST_FROZEN_BIT = 3;
  localparam int unsigned ST_ENABLE_BIT = 4;
  localparam int unsigned ST_RX_BIT     = 5;

  // Bus-off entry and recovery figures.
  localparam logic [8:0]  BUSOFF_LIMIT       = 9'h0FF;
  localparam int unsigned RECESSIVE_RUN_BITS = 11;
  localparam int unsigned RECESSIVE_RUNS     = 128;

  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'b00,
    MODE_INIT   = 2'b01,
    MODE_NORMAL = 2'b10
  } mode_e;

endpackage

/* core/recessive_run_counter.sv */
// Purpose: Counts runs of consecutive recessive bits for bus-off recovery.
// Assumes: bit_tick marks one sample point per bit, rx_level is synchronised.
// Notes:   done pulses once when the run total is reached.
`timescale 1ns/1ps
module recessive_run_counter #(
  parameter int unsigned RUN_BITS = 11,
  parameter int unsigned RUNS     = 128
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bit stream
  input  wire logic enable,
  input  wire logic bit_tick,
  input  wire logic rx_level,
  // Result
  output logic      done
);

  localparam int unsigned BIT_W = $clog2(RUN_BITS + 1);
  localparam int unsigned RUN_W = $clog2(RUNS + 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(RUN_BITS - 1);
  localparam logic [RUN_W-1:0] LAST_RUN = RUN_W'(RUNS - 1);

  logic [BIT_W-1:0] bit_cnt_reg;
  logic [BIT_W-1:0] bit_cnt_next;
  logic [RUN_W-1:0] run_cnt_reg;
  logic [RUN_W-1:0] run_cnt_next;
  logic             done_reg;
  logic             done_next;

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    run_cnt_next = run_cnt_reg;
    done_next    = 1'b0;
    if (!enable) begin
      bit_cnt_next = '0;
      run_cnt_next = '0;
    end else if (bit_tick) begin
      // A dominant bit breaks the run; only whole runs count.
      if (!rx_level) begin
        bit_cnt_next = '0;
      end else if (bit_cnt_reg == LAST_BIT) begin
        bit_cnt_next = '0;
        if (run_cnt_reg == LAST_RUN) begin
          run_cnt_next = '0;
          done_next    = 1'b1;
        end else begin
          run_cnt_next = run_cnt_reg + 1'b1;
        end
      end else begin
        bit_cnt_next = bit_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= '0;
      run_cnt_reg <= '0;
      done_reg    <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      run_cnt_reg <= run_cnt_next;
      done_reg    <= done_next;
    end
  end

  assign done = done_reg;

endmodule

/* verif/can_bus_node_model.sv */
// Purpose: Behavioural model of the other nodes on the shared CAN bus.
// Assumes: One bit every BIT_CYCLES pclk cycles; the bus rests recessive.
// Notes:   The bench asks for dominant bits through drive_dominant.
`timescale 1ns/1ps
module can_bus_node_model #(
  parameter int unsigned BIT_CYCLES = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench control
  input  wire logic drive_dominant,
  // Bus side
  output logic      can_rx,
  output logic      bit_tick
);
  logic [7:0] phase_reg;
  logic [7:0] phase_next;
  logic       tick_next;

  always_comb begin
    tick_next  = (phase_reg == 8'(BIT_CYCLES - 1));
    phase_next = tick_next ? 8'h00 : phase_reg + 8'h01;
  end

  // Sample points keep coming while the bus idles, so recessive runs can be counted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 8'h00;
      bit_tick  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      bit_tick  <= tick_next;
    end
  end

  // bus level
  // A released bus is pulled recessive; it is dominant only while a node drives it.
  assign can_rx = ~drive_dominant;
endmodule

/* verif/can_main_control_modes_test.sv */
// Purpose: Self-checking bench of the CAN main control block.
// Assumes: Zero wait state APB slave; bus model ticks every 4 cycles.
// Notes:   Bus-off recovery runs the full 128 runs of 11 bits.
`timescale 1ns/1ps
module can_main_control_modes_test;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        can_rx;
  logic        bit_tick;
  logic        drive_dominant;
  logic [8:0]  tx_error_counter;
  logic        debug_halt;
  logic        init_mode;
  logic        sleep_mode;
  logic        busoff_flag;
  logic        bus_enable;
  logic        tx_priority_select;
  logic        rx_lock_select;
  logic        retransmit_disable;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          checks;
  int          cycles;

  typedef struct packed {
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [4:0]  mode;
  } row_s;

  // Mode bits are init, sleep, tx priority, rx lock, retransmit disable.
  row_s rows [8] = '{
    '{32'h0001_0000, 32'h0001_0000, 5'b00000},
    '{32'h0000_0001, 32'h0000_0001, 5'b10000},
    '{32'h0000_001C, 32'h0000_001C, 5'b00111},
    '{32'h0000_0004, 32'h0000_0004, 5'b00100},
    '{32'h0000_0008, 32'h0000_0008, 5'b00010},
    '{32'h0000_0010, 32'h0000_0010, 5'b00001},
    '{32'h0000_0002, 32'h0000_0002, 5'b01000},
    '{32'hFFFF_FF80, 32'h0001_0000, 5'b00000}
  };

  can_bus_node_model #(.BIT_CYCLES(4)) bus_node (
    .pclk(pclk), .presetn(presetn), .drive_dominant(drive_dominant), .can_rx(can_rx), .bit_tick(bit_tick));

  can_main_control_modes DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .bit_tick(bit_tick), .tx_error_counter(tx_error_counter), .debug_halt(debug_halt),
    .init_mode(init_mode), .sleep_mode(sleep_mode), .busoff_flag(busoff_flag), .bus_enable(bus_enable),
    .tx_priority_select(tx_priority_select), .rx_lock_select(rx_lock_select),
    .retransmit_disable(retransmit_disable));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The setup edge is one edge after entry, so no signal is assigned twice in a time step.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) check(1'b0, 1'b1, "pready timeout");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_busoff_clear(input int lim);
    int n;
    n = 0;
    while (busoff_flag !== 1'b0 && n < lim) begin
      n++;
      @(posedge pclk);
    end
    check(busoff_flag, 32'h0, "bus-off not left");
  endtask

  task automatic pulse_dominant();
    drive_dominant <= 1'b1;
    wait_cycles(12);
    drive_dominant <= 1'b0;
    wait_cycles(10);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      check(1'b0, 1'b1, "run timeout");
      print_verdict();
    end
  end

  initial begin
    {bad_count, checks, cycles} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, drive_dominant, tx_error_counter, debug_halt} = '0;
    wait_cycles(6);
    presetn <= 1'b1;
    check(sleep_mode, 32'h1, "sleep after reset");
    apb(1'b0, can_main_control_pkg::MAIN_CONTROL_OFFSET, 32'h0);
    check(rd, can_main_control_pkg::MAIN_CONTROL_RESET, "control reset");
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, rows[i].wdata);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, rows[i].rdata, "control readback");
      check({init_mode, sleep_mode, tx_priority_select, rx_lock_select, retransmit_disable},
            rows[i].mode, "mode outputs");
    end
    apb(1'b0, 12'h008, 32'h0);
    check(er, 32'h1, "unmapped read error");
    check(rd, 32'h0, "unmapped read data");
    apb(1'b1, 12'h000, 32'h0000_0002);
    pulse_dominant();
    check(sleep_mode, 32'h1, "woke without auto wakeup");
    apb(1'b1, 12'h000, 32'h0000_0022);
    pulse_dominant();
    check(sleep_mode, 32'h0, "no auto wakeup");
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_0020, "sleep bit not cleared");
    apb(1'b1, 12'h000, 32'h0000_0040);
    tx_error_counter <= 9'h0FF;
    wait_cycles(3);
    check(busoff_flag, 32'h0, "bus-off at 255");
    tx_error_counter <= 9'h100;
    wait_cycles(3);
    check({busoff_flag, bus_enable}, 32'h2, "bus-off entry");
    tx_error_counter <= 9'h000;
    apb(1'b0, can_main_control_pkg::MODE_STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_0024, "status in bus-off");
    wait_cycles(5500);
    check(busoff_flag, 32'h1, "left bus-off early");
    wait_busoff_clear(600);
    apb(1'b1, 12'h000, 32'h0);
    tx_error_counter <= 9'h100;
    wait_cycles(3);
    tx_error_counter <= 9'h000;
    wait_cycles(6000);
    check(busoff_flag, 32'h1, "left bus-off without init");
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0);
    wait_busoff_clear(6000);
    apb(1'b1, 12'h000, 32'h0001_0000);
    debug_halt <= 1'b1;
    wait_cycles(3);
    check(bus_enable, 32'h0, "not frozen");
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0001_0000, "access while halted");
    debug_halt <= 1'b0;
    wait_cycles(3);
    check(bus_enable, 32'h1, "stuck frozen");
    apb(1'b1, 12'h000, 32'h0);
    debug_halt <= 1'b1;
    wait_cycles(3);
    check(bus_enable, 32'h1, "frozen with freeze off");
    debug_halt <= 1'b0;
    presetn    <= 1'b0;
    wait_cycles(2);
    check({init_mode, sleep_mode}, 32'h1, "mid-run reset");
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0001_0002, "control after reset");
    print_verdict();
  end
endmodule
